// >>> src/fifo_pkg.sv
// shared constants and helpers for the flagged fifo and its controller
package fifo_pkg;
  // ----------------------------------------
  // geometry
  // ----------------------------------------
  localparam int DATA_W = 9;
  localparam int ADDR_W = 6;
  localparam int PTR_W = 7;
  localparam logic [6:0] DEPTH = 7'h40;
  // ----------------------------------------
  // flag offset defaults
  // ----------------------------------------
  localparam logic [5:0] DEFAULT_EMPTY_OFS = 6'h07;
  localparam logic [5:0] DEFAULT_FULL_OFS = 6'h07;
  // ----------------------------------------
  // offset load sequence steps
  // ----------------------------------------
  localparam logic [1:0] STEP_EMPTY_LSB = 2'h0;
  localparam logic [1:0] STEP_FULL_LSB = 2'h2;
  // ----------------------------------------
  // controller register map (byte addresses)
  // ----------------------------------------
  localparam logic [3:0] REG_DATA = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_OFFSET = 4'h8;
  localparam logic [3:0] REG_CTRL = 4'hc;
  localparam logic [1:0] CTRL_RESET = 2'h1;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [6:0] bin2gray(input logic [6:0] b);
    bin2gray = b ^ (b >> 1);
  endfunction

  function automatic logic [6:0] gray2bin(input logic [6:0] g);
    logic [6:0] b;
    b[6] = g[6];
    for (int i = 5; i >= 0; i--) begin
      b[i] = b[i + 1] ^ g[i];
    end
    gray2bin = b;
  endfunction
endpackage

// >>> src/fifo_link_if.sv
// pin-level link between the fifo device and the system controller
`timescale 1ns/10ps
`default_nettype none
interface fifo_link_if;
  logic [8:0] data_to_fifo;
  logic [8:0] data_from_fifo;
  logic write_enable_primary_n;
  logic write_enable_or_load;
  logic read_enable_primary_n;
  logic read_enable_secondary_n;
  logic empty_flag_n;
  logic full_flag_n;
  logic almost_full_flag_n;
  logic almost_empty_flag_n;

  modport device (
    input data_to_fifo, write_enable_primary_n, write_enable_or_load,
    input read_enable_primary_n, read_enable_secondary_n,
    output data_from_fifo, empty_flag_n, full_flag_n,
    output almost_full_flag_n, almost_empty_flag_n
  );
  modport controller (
    output data_to_fifo, write_enable_primary_n, write_enable_or_load,
    output read_enable_primary_n, read_enable_secondary_n,
    input data_from_fifo, empty_flag_n, full_flag_n,
    input almost_full_flag_n, almost_empty_flag_n
  );
endinterface
`default_nettype wire

// >>> src/ptr_sync.sv
// two-stage synchroniser for a gray-coded pointer
`timescale 1ns/10ps
`default_nettype none
module ptr_sync #(
  parameter int WIDTH = 7
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // pointer
  input wire logic [WIDTH-1:0] gray_in,
  output logic [WIDTH-1:0] gray_out
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      stage1 <= '0;
      gray_out <= '0;
    end else begin
      stage1 <= gray_in;
      gray_out <= stage1;
    end
  end
endmodule
`default_nettype wire

// >>> src/fifo_device.sv
// 64 x 9 fifo with empty, full and programmable almost flags
//
// Added by the designer: the register offsets and the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none
// How it works
// - first word out within bounded read cycles
// - latency bound holds only when empty
// - almost-full may lag a read by three edges
// - almost-empty may lag a write by three edges
// - write at threshold leaves depth minus m-1
// - read at threshold leaves n-1 words
// - load pin low at reset: offset control
// - load pin high at reset: second enable
// - second-enable mode keeps default offsets
// - secondary read enable may be tied active
// - width expansion shares controls in parallel
// - composite empty and full across devices
// - almost flags taken from any device
// - one enable system, other steering
// - expansion steps devices in fixed order
// - full flag low at full depth
// - empty flag low when pointers equal
// - almost-full offset defaults to seven
// - almost-empty offset defaults to seven
module fifo_device (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // fifo pins
  fifo_link_if.device link,
  // mode seen at reset
  output logic load_mode_out
);
  // ----------------------------------------
  // storage and state
  // ----------------------------------------
  logic [8:0] mem [0:63];
  logic [6:0] wptr;
  logic [6:0] rptr;
  logic [6:0] wgray;
  logic [6:0] rgray;
  logic [6:0] wgray_sync;
  logic [6:0] rgray_sync;
  logic [5:0] empty_ofs;
  logic [5:0] full_ofs;
  logic [1:0] wr_step;
  logic [1:0] rd_step;
  logic strap_pending;
  logic load_mode;
  logic do_write;
  logic do_read;
  logic ofs_write;
  logic ofs_read;
  logic [6:0] next_wptr;
  logic [6:0] next_rptr;
  logic [6:0] wr_count;
  logic [6:0] rd_count;

  assign load_mode_out = load_mode;

  // ----------------------------------------
  // reset strap of the shared pin
  // ----------------------------------------
  // caught on the first edge after release, never under reset itself
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      strap_pending <= 1'b1;
      load_mode <= 1'b0;
    end else if (strap_pending) begin
      strap_pending <= 1'b0;
      load_mode <= ~link.write_enable_or_load;
    end
  end

  // ----------------------------------------
  // decode of the enables
  // ----------------------------------------
  always_comb begin
    // pin high acts as write enable in both modes; low loads only in load mode
    do_write = ~strap_pending & ~link.write_enable_primary_n
      & link.write_enable_or_load & link.full_flag_n;
    ofs_write = ~strap_pending & load_mode & ~link.write_enable_or_load
      & ~link.write_enable_primary_n;
    do_read = ~strap_pending & ~link.read_enable_primary_n
      & ~link.read_enable_secondary_n & link.empty_flag_n
      & ~(load_mode & ~link.write_enable_or_load);
    ofs_read = ~strap_pending & load_mode & ~link.write_enable_or_load
      & ~link.read_enable_primary_n & ~link.read_enable_secondary_n;
    next_wptr = wptr + {6'h00, do_write};
    next_rptr = rptr + {6'h00, do_read};
    wr_count = next_wptr - fifo_pkg::gray2bin(rgray_sync);
    rd_count = fifo_pkg::gray2bin(wgray_sync) - next_rptr;
  end

  // ----------------------------------------
  // pointer crossing
  // ----------------------------------------
  // both sides still pay two stages so the flags never see a moving pointer
  ptr_sync #(.WIDTH(fifo_pkg::PTR_W)) sync_w2r (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .gray_in(wgray),
    .gray_out(wgray_sync)
  );
  ptr_sync #(.WIDTH(fifo_pkg::PTR_W)) sync_r2w (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .gray_in(rgray),
    .gray_out(rgray_sync)
  );

  // ----------------------------------------
  // write side
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (do_write) begin
      mem[wptr[5:0]] <= link.data_to_fifo;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wptr <= '0;
      wgray <= '0;
    end else begin
      wptr <= next_wptr;
      wgray <= fifo_pkg::bin2gray(next_wptr);
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      link.full_flag_n <= 1'b1;
      link.almost_full_flag_n <= 1'b1;
    end else begin
      link.full_flag_n <= (wr_count != fifo_pkg::DEPTH);
      // threshold counts the word taken on this edge
      link.almost_full_flag_n <= (wr_count < (fifo_pkg::DEPTH - {1'b0, full_ofs}));
    end
  end

  // ----------------------------------------
  // offset registers
  // ----------------------------------------
  // upper words of the sequence are accepted but unused at this depth
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      empty_ofs <= fifo_pkg::DEFAULT_EMPTY_OFS;
      full_ofs <= fifo_pkg::DEFAULT_FULL_OFS;
      wr_step <= fifo_pkg::STEP_EMPTY_LSB;
    end else if (ofs_write) begin
      wr_step <= wr_step + 2'h1;
      if (wr_step == fifo_pkg::STEP_EMPTY_LSB) begin
        empty_ofs <= link.data_to_fifo[5:0];
      end
      if (wr_step == fifo_pkg::STEP_FULL_LSB) begin
        full_ofs <= link.data_to_fifo[5:0];
      end
    end
  end

  // ----------------------------------------
  // read side
  // ----------------------------------------
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rptr <= '0;
      rgray <= '0;
    end else begin
      rptr <= next_rptr;
      rgray <= fifo_pkg::bin2gray(next_rptr);
    end
  end

  // offset reads walk the same four-step order as offset writes
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rd_step <= fifo_pkg::STEP_EMPTY_LSB;
    end else if (ofs_read) begin
      rd_step <= rd_step + 2'h1;
    end
  end

  // output word holds between reads
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      link.data_from_fifo <= '0;
    end else if (do_read) begin
      link.data_from_fifo <= mem[rptr[5:0]];
    end else if (ofs_read) begin
      case (rd_step)
        fifo_pkg::STEP_EMPTY_LSB: link.data_from_fifo <= {3'h0, empty_ofs};
        fifo_pkg::STEP_FULL_LSB: link.data_from_fifo <= {3'h0, full_ofs};
        default: link.data_from_fifo <= '0;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      link.empty_flag_n <= 1'b0;
      link.almost_empty_flag_n <= 1'b0;
    end else begin
      link.empty_flag_n <= (rd_count != 7'h00);
      link.almost_empty_flag_n <= (rd_count > {1'b0, empty_ofs});
    end
  end
endmodule
`default_nettype wire

// >>> src/fifo_controller.sv
// system-side controller driving the fifo pins from avalon-mm registers
`timescale 1ns/10ps
`default_nettype none
module fifo_controller #(
  parameter bit EXPANSION_MODE = 1'b0
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // avalon-mm slave
  input wire logic [3:0] address_in,
  input wire logic read_in,
  input wire logic write_in,
  input wire logic [31:0] writedata_in,
  output logic [31:0] readdata_out,
  output logic waitrequest_out,
  // fifo pins
  fifo_link_if.controller link
);
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_WR = 2'b01,
    S_RD_PULSE = 2'b10,
    S_RD_DONE = 2'b11
  } state_t;

  state_t state;
  state_t next_state;
  logic [1:0] ctrl;
  logic start_wr;
  logic start_ofs;
  logic start_rd;

  // ----------------------------------------
  // request decode
  // ----------------------------------------
  always_comb begin
    start_wr = (state == S_IDLE) & write_in & (address_in == fifo_pkg::REG_DATA)
      & link.full_flag_n;
    start_ofs = (state == S_IDLE) & write_in & (address_in == fifo_pkg::REG_OFFSET);
    start_rd = (state == S_IDLE) & read_in & (address_in == fifo_pkg::REG_DATA)
      & link.empty_flag_n;
    next_state = state;
    waitrequest_out = 1'b1;
    readdata_out = '0;
    case (state)
      S_IDLE: begin
        if (start_wr | start_ofs) begin
          waitrequest_out = 1'b0;
          next_state = S_WR;
        end else if (start_rd) begin
          next_state = S_RD_PULSE;
        end else if (write_in & (address_in == fifo_pkg::REG_DATA)) begin
          waitrequest_out = 1'b1;
        end else if (read_in & (address_in == fifo_pkg::REG_DATA)) begin
          waitrequest_out = 1'b1;
        end else if (read_in | write_in) begin
          waitrequest_out = 1'b0;
          if (address_in == fifo_pkg::REG_STATUS) begin
            // composite view of this device's flags
            readdata_out = {28'h0000000, link.almost_empty_flag_n,
              link.almost_full_flag_n, link.full_flag_n, link.empty_flag_n};
          end else if (address_in == fifo_pkg::REG_CTRL) begin
            readdata_out = {30'h00000000, ctrl};
          end
        end
      end
      S_WR: begin
        next_state = S_IDLE;
      end
      S_RD_PULSE: begin
        next_state = S_RD_DONE;
      end
      S_RD_DONE: begin
        waitrequest_out = 1'b0;
        readdata_out = {23'h000000, link.data_from_fifo};
        next_state = S_IDLE;
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // state and control register
  // ----------------------------------------
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state <= S_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // bit0 steers the second write enable, bit1 is the secondary read enable
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl <= fifo_pkg::CTRL_RESET;
    end else if ((state == S_IDLE) & write_in & (address_in == fifo_pkg::REG_CTRL)) begin
      ctrl <= writedata_in[1:0];
    end
  end

  // ----------------------------------------
  // pin drive
  // ----------------------------------------
  // one write per two cycles so the registered full flag is never stale
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      link.write_enable_primary_n <= 1'b1;
      link.write_enable_or_load <= EXPANSION_MODE;
      link.data_to_fifo <= '0;
    end else begin
      link.write_enable_primary_n <= ~(start_wr | start_ofs);
      if (start_ofs) begin
        link.write_enable_or_load <= 1'b0;
      end else begin
        link.write_enable_or_load <= ctrl[0];
      end
      if (start_wr | start_ofs) begin
        link.data_to_fifo <= writedata_in[8:0];
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      link.read_enable_primary_n <= 1'b1;
      link.read_enable_secondary_n <= 1'b0;
    end else begin
      link.read_enable_primary_n <= ~start_rd;
      link.read_enable_secondary_n <= ctrl[1];
    end
  end
endmodule
`default_nettype wire

// >>> testbench/fifo_link_checker.sv
// pin-level assertions between the fifo device and its controller
`timescale 1ns/10ps
`default_nettype none
module fifo_link_checker (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // link signals
  input wire logic write_enable_primary_n,
  input wire logic write_enable_or_load,
  input wire logic read_enable_primary_n,
  input wire logic read_enable_secondary_n,
  input wire logic empty_flag_n,
  input wire logic full_flag_n,
  input wire logic almost_full_flag_n,
  input wire logic almost_empty_flag_n
);
  // ----------------------------------------
  // word count and edge ages
  // ----------------------------------------
  logic wr_ok;
  logic rd_ok;
  logic [6:0] count;
  logic [2:0] wr_age;
  logic [2:0] rd_age;
  assign wr_ok = !write_enable_primary_n && write_enable_or_load && full_flag_n;
  assign rd_ok = !read_enable_primary_n && !read_enable_secondary_n && empty_flag_n;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      count <= 7'h00;
    end else begin
      count <= count + 7'(wr_ok) - 7'(rd_ok);
    end
  end
  // ages saturate so the flag lag of the far pointer is settled
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wr_age <= 3'h7;
      rd_age <= 3'h7;
    end else begin
      wr_age <= wr_ok ? 3'h0 : (wr_age == 3'h7 ? wr_age : wr_age + 3'h1);
      rd_age <= rd_ok ? 3'h0 : (rd_age == 3'h7 ? rd_age : rd_age + 3'h1);
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  AST_FULL_AT_DEPTH: assert property (count == 7'h40 |-> !full_flag_n)
    else $error("full flag high at full depth");
  AST_EMPTY_AT_ZERO: assert property (count == 7'h00 |-> !empty_flag_n)
    else $error("empty flag high with no words");
  AST_FULL_EXACT: assert property (rd_age >= 3'h5 |-> full_flag_n == (count != 7'h40))
    else $error("full flag wrong once settled");
  AST_EMPTY_EXACT: assert property (wr_age >= 3'h5 |-> empty_flag_n == (count != 7'h00))
    else $error("empty flag wrong once settled");
  AST_ALMOST_FULL: assert property (rd_age >= 3'h5 |-> almost_full_flag_n == (count < 7'h39))
    else $error("almost-full flag wrong for default offset");
  AST_ALMOST_EMPTY: assert property (wr_age >= 3'h5 |-> almost_empty_flag_n == (count > 7'h07))
    else $error("almost-empty flag wrong for default offset");
  AST_FIRST_WORD: assert property (wr_ok && count == 7'h00 |-> ##[3:4] empty_flag_n)
    else $error("first word latency exceeded");
  AST_WRITE_PULSE: assert property (!write_enable_primary_n |=> write_enable_primary_n)
    else $error("write enable held longer than one cycle");
  AST_READ_PULSE: assert property (!read_enable_primary_n |=> read_enable_primary_n)
    else $error("read enable held longer than one cycle");
  COV_FULL: cover property (!full_flag_n);
  COV_FIRST_WORD: cover property (wr_ok && count == 7'h00);
  COV_ALMOST_EMPTY: cover property ($fell(almost_empty_flag_n));
endmodule
`default_nettype wire

// >>> testbench/tb.sv
// self-checking bench for the fifo device and its controller
`timescale 1ns/10ps
`default_nettype none
module tb;
  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  localparam int DEPTH_N = int'(fifo_pkg::DEPTH);
  localparam int AF_AT = DEPTH_N - int'(fifo_pkg::DEFAULT_FULL_OFS);
  localparam int AE_N = int'(fifo_pkg::DEFAULT_EMPTY_OFS);
  // empty offset that the load-strapped pair picks up from the dropped-enable write
  localparam int AE_LD = 1;
  logic clk_in;
  logic rst_b_in;
  logic [3:0] address_in;
  logic read_in;
  logic write_in;
  logic [31:0] writedata_in;
  logic [31:0] readdata_out;
  logic waitrequest_out;
  logic load_mode_out;
  logic load_mode_b;
  logic [31:0] readdata_ld;
  logic waitrequest_ld;
  logic [31:0] exp_q[$];
  logic [31:0] exp_ld_q[$];
  logic [8:0] word_q[$];
  logic [31:0] seed;
  int err_count;
  int n_tests;
  fifo_link_if link();
  fifo_link_if link_b();
  fifo_device i_fifo_device (.clk_in(clk_in), .rst_b_in(rst_b_in), .link(link),
    .load_mode_out(load_mode_out));
  fifo_controller #(.EXPANSION_MODE(1'b1)) i_fifo_controller (.clk_in(clk_in),
    .rst_b_in(rst_b_in), .address_in(address_in), .read_in(read_in), .write_in(write_in),
    .writedata_in(writedata_in), .readdata_out(readdata_out),
    .waitrequest_out(waitrequest_out), .link(link));
  // strapped low pair sees the same bus traffic, so its offset load shows in status
  fifo_device i_fifo_device_ld (.clk_in(clk_in), .rst_b_in(rst_b_in), .link(link_b),
    .load_mode_out(load_mode_b));
  fifo_controller i_fifo_controller_ld (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .address_in(address_in), .read_in(read_in), .write_in(write_in),
    .writedata_in(writedata_in), .readdata_out(readdata_ld),
    .waitrequest_out(waitrequest_ld), .link(link_b));
  fifo_link_checker i_fifo_link_checker (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .write_enable_primary_n(link.write_enable_primary_n),
    .write_enable_or_load(link.write_enable_or_load),
    .read_enable_primary_n(link.read_enable_primary_n),
    .read_enable_secondary_n(link.read_enable_secondary_n),
    .empty_flag_n(link.empty_flag_n), .full_flag_n(link.full_flag_n),
    .almost_full_flag_n(link.almost_full_flag_n),
    .almost_empty_flag_n(link.almost_empty_flag_n));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] status(input int n, input int ae);
    return {28'h0, n > ae, n < AF_AT, n != DEPTH_N, n != 0};
  endfunction
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("errors %0d checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // one avalon transfer, held until waitrequest is seen low at a rising edge
  task automatic bus(input logic [3:0] a, input logic rd, input logic [31:0] d);
    @(posedge clk_in);
    address_in <= a;
    read_in <= rd;
    write_in <= !rd;
    writedata_in <= d;
    do begin
      @(posedge clk_in);
    end while (waitrequest_out);
    read_in <= 1'b0;
    write_in <= 1'b0;
  endtask
  task automatic rd_exp(input logic [3:0] a, input logic [31:0] e, input logic [31:0] e_ld);
    exp_q.push_back(e);
    exp_ld_q.push_back(e_ld);
    bus(a, 1'b1, 32'h0);
  endtask
  // read data taken at the same edge that sees waitrequest low
  always @(posedge clk_in) begin
    if (read_in && !waitrequest_out && exp_q.size() > 0) begin
      check("readdata", readdata_out, exp_q.pop_front());
      check("waitrequest_ld", {31'h0, waitrequest_ld}, 32'h0);
      check("readdata_ld", readdata_ld, exp_ld_q.pop_front());
    end
  end
  // ----------------------------------------
  // clock, watchdog and sequence
  // ----------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  initial begin
    repeat (20000) @(posedge clk_in);
    err_count++;
    end_sim();
  end
  initial begin
    logic [8:0] w;
    rst_b_in = 1'b0;
    address_in = 4'h0;
    read_in = 1'b0;
    write_in = 1'b0;
    writedata_in = 32'h0;
    err_count = 0;
    n_tests = 0;
    seed = 32'h1fd2a25f;
    repeat (8) @(posedge clk_in);
    rst_b_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    check("load_mode", {31'h0, load_mode_out}, 32'h0);
    check("load_mode_b", {31'h0, load_mode_b}, 32'h1);
    rd_exp(fifo_pkg::REG_STATUS, status(0, AE_N), status(0, AE_LD));
    bus(4'h2, 1'b0, 32'hffff_ffff);
    rd_exp(4'h2, 32'h0, 32'h0);
    // second enable dropped: no word stored; the load-strapped pair loads its empty offset
    bus(fifo_pkg::REG_CTRL, 1'b0, 32'h0);
    bus(fifo_pkg::REG_DATA, 1'b0, 32'(AE_LD));
    bus(fifo_pkg::REG_CTRL, 1'b0, 32'h1);
    repeat (5) @(posedge clk_in);
    rd_exp(fifo_pkg::REG_STATUS, status(0, AE_N), status(0, AE_LD));
    bus(fifo_pkg::REG_OFFSET, 1'b0, 32'h2);
    for (int i = 1; i <= DEPTH_N; i++) begin
      seed = lfsr(seed);
      w = seed[8:0];
      word_q.push_back(w);
      bus(fifo_pkg::REG_DATA, 1'b0, {23'h0, w});
      repeat (5) @(posedge clk_in);
      rd_exp(fifo_pkg::REG_STATUS, status(i, AE_N), status(i, AE_LD));
    end
    for (int i = DEPTH_N - 1; i >= 0; i--) begin
      w = word_q.pop_front();
      rd_exp(fifo_pkg::REG_DATA, {23'h0, w}, {23'h0, w});
      repeat (5) @(posedge clk_in);
      rd_exp(fifo_pkg::REG_STATUS, status(i, AE_N), status(i, AE_LD));
    end
    // read issued while the first word is still crossing
    bus(fifo_pkg::REG_DATA, 1'b0, 32'h155);
    rd_exp(fifo_pkg::REG_DATA, 32'h155, 32'h155);
    // let the watcher take the last answer before the queues are looked at
    repeat (2) @(posedge clk_in);
    check("pending", exp_q.size() + exp_ld_q.size(), 32'h0);
    end_sim();
  end
endmodule
`default_nettype wire
